// file: hw/ldc_pkg.sv
package ldc_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;
   localparam int MEM_AW = 15;
   localparam int MEM_DEPTH = 32768;
   // Indirect command bytes.
   localparam logic [7:0] CMD_GLYPH_BASE = 8'h5C;
   localparam logic [7:0] CMD_FINE_HSCROLL = 8'h5A;
   localparam logic [7:0] CMD_SET_POINTER = 8'h46;
   localparam logic [7:0] CMD_READ_POINTER = 8'h47;
   localparam logic [7:0] CMD_DEPTH = 8'h60;
   localparam logic [7:0] CMD_MEM_WRITE = 8'h42;
   localparam logic [7:0] CMD_MEM_READ = 8'h43;
   // Direct register offsets.
   localparam logic [15:0] OFS_GLYPH_BASE_LOW = 16'h8019;
   localparam logic [15:0] OFS_GLYPH_BASE_HIGH = 16'h801A;
   localparam logic [15:0] OFS_FINE_HSCROLL = 16'h801B;
   localparam logic [15:0] OFS_CURSOR_WR_LOW = 16'h801C;
   localparam logic [15:0] OFS_CURSOR_WR_HIGH = 16'h801D;
   localparam logic [15:0] OFS_CURSOR_RB_LOW = 16'h801E;
   localparam logic [15:0] OFS_CURSOR_RB_HIGH = 16'h801F;
   localparam logic [15:0] OFS_PIXEL_DEPTH = 16'h8020;
   localparam int REG_SPACE_BIT = 15;
   // Field layouts and reset values.
   localparam int HSCROLL_W = 3;
   localparam int DEPTH_W = 2;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [15:0] CURSOR_STEP = 16'h0001;
   localparam logic [1:0] DEPTH_1BPP = 2'h0;
   localparam logic [1:0] DEPTH_2BPP = 2'h1;
   localparam logic [1:0] DEPTH_4BPP = 2'h2;
   localparam logic [1:0] DEPTH_RSVD = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE, ST_GLYPH, ST_HSCROLL, ST_PTR_SET, ST_PTR_RD, ST_DEPTH,
      ST_MWR, ST_MRD
   } ldc_state_e;
   typedef struct packed {
      ldc_state_e state;
      logic idx;
      logic [15:0] glyph_base;
      logic [7:0] hscroll;
      logic [15:0] cursor;
      logic [7:0] depth;
      logic [7:0] dout;
      logic dout_vld;
      logic rd_pend;
      logic [15:0] glyph_addr;
      logic [7:0] scrolled;
   } ldc_state_s;
endpackage

// file: hw/ldc_mem.sv
`timescale 1ns/1ps
module ldc_mem import ldc_pkg::*; (
   input wire logic clk, // Core clock.
   input wire logic ce, // Clock enable.
   input wire logic we, // Write strobe.
   input wire logic [MEM_AW-1:0] waddr, // Write address.
   input wire logic [DATA_W-1:0] wdata, // Write data.
   input wire logic [MEM_AW-1:0] raddr, // Read address.
   output logic [DATA_W-1:0] rdata // Registered read data.
);
   logic [DATA_W-1:0] mem_reg [MEM_DEPTH];

   // No reset on the array so it maps onto block RAM.
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem_reg[waddr] <= wdata;
         end
         rdata <= mem_reg[raddr];
      end
   end
endmodule // ldc_mem

// file: hw/ldc_draw_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Glyph base is two byte registers, low then high, reset zero, R/W.
// - Glyph address is code times height plus glyph base.
// - Glyph base command loads its two bytes, low then high.
// - Display shifts left by the 3-bit fine scroll pixel count.
// - Fine scroll acts on the composed display, never one layer.
// - Memory read and write commands use the 16-bit cursor.
// - Cursor changes only by set-pointer, direct cursor writes or memory auto-increment.
// - Without reload, accesses continue from last address plus increments.
// - Indirect mode refuses direct host access to display memory.
// - Set-pointer command loads its two bytes into the cursor.
// - Cursor is visible through two read-only bytes, reset zero.
// - After read-pointer, two reads return cursor low then high.
// - Depth field 00/01/10 is 1/2/4 bpp, 11 reserved, reset zero.
// - Depth command loads its parameter into the depth register.
// - Depth command byte 60h takes exactly one parameter byte.
module ldc_draw_ctrl import ldc_pkg::*; (
   input wire logic clk, // Core clock, 40 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire logic indirect_mode, // High selects indirect addressing.
   input wire logic cmd_we, // Indirect command byte strobe.
   input wire logic par_we, // Indirect parameter or data write strobe.
   input wire logic par_re, // Indirect parameter or data read strobe.
   input wire logic [7:0] bus_din, // Host write data.
   input wire logic dir_wr, // Direct write strobe.
   input wire logic dir_rd, // Direct read strobe.
   input wire logic [15:0] dir_addr, // Direct address.
   input wire logic [7:0] char_code, // Character code from text fetch.
   input wire logic [4:0] char_height, // Character height in rows.
   input wire logic [15:0] comp_word, // Two adjacent composed bytes.
   output logic [7:0] bus_dout, // Host read data.
   output logic bus_dout_vld, // Read data valid pulse.
   output logic [15:0] glyph_base, // Glyph RAM base address.
   output logic [15:0] glyph_addr, // Glyph start address.
   output logic [2:0] hscroll_px, // Fine horizontal scroll count.
   output logic [7:0] scrolled_byte, // Composed byte after fine scroll.
   output logic [15:0] cursor_addr, // Current cursor address.
   output logic [1:0] depth_sel, // Pixel depth field.
   output logic bpp_one, // One bit per pixel selected.
   output logic bpp_two, // Two bits per pixel selected.
   output logic bpp_four, // Four bits per pixel selected.
   output logic bpp_rsvd // Reserved depth code selected.
);
   ldc_state_s s_reg, s_next;
   logic mem_we;
   logic [MEM_AW-1:0] mem_waddr, mem_raddr;
   logic [7:0] mem_wdata, mem_rdata;
   logic [15:0] shifted, glyph_calc;
   logic is_mem;

   ldc_mem u_mem (
      .clk(clk),
      .ce(ce),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   assign glyph_calc = ({8'h00, char_code} * {11'h000, char_height})
      + s_reg.glyph_base;
   assign shifted = comp_word << s_reg.hscroll[HSCROLL_W-1:0];
   assign is_mem = !dir_addr[REG_SPACE_BIT];

   always_comb begin
      s_next = s_reg;
      s_next.dout_vld = 1'b0;
      s_next.glyph_addr = glyph_calc;
      // Shift applies after layer composition, so all layers move.
      s_next.scrolled = shifted[15:8];
      mem_we = 1'b0;
      mem_wdata = bus_din;
      mem_waddr = s_reg.cursor[MEM_AW-1:0];
      mem_raddr = indirect_mode ? s_reg.cursor[MEM_AW-1:0]
                                : dir_addr[MEM_AW-1:0];
      if (s_reg.rd_pend) begin
         s_next.dout = mem_rdata;
         s_next.dout_vld = 1'b1;
         s_next.rd_pend = 1'b0;
      end
      if (indirect_mode) begin
         // The direct port is ignored here: memory only via cursor.
         s_next.rd_pend = 1'b0;
         if (cmd_we) begin
            s_next.idx = 1'b0;
            case (bus_din)
               CMD_GLYPH_BASE: s_next.state = ST_GLYPH;
               CMD_FINE_HSCROLL: s_next.state = ST_HSCROLL;
               CMD_SET_POINTER: s_next.state = ST_PTR_SET;
               CMD_READ_POINTER: s_next.state = ST_PTR_RD;
               CMD_DEPTH: s_next.state = ST_DEPTH;
               CMD_MEM_WRITE: s_next.state = ST_MWR;
               CMD_MEM_READ: s_next.state = ST_MRD;
               default: s_next.state = ST_IDLE;
            endcase
         end else if (par_we) begin
            case (s_reg.state)
               ST_GLYPH: begin
                  if (!s_reg.idx) begin
                     s_next.glyph_base[7:0] = bus_din;
                     s_next.idx = 1'b1;
                  end else begin
                     s_next.glyph_base[15:8] = bus_din;
                     s_next.state = ST_IDLE;
                  end
               end
               ST_HSCROLL: begin
                  s_next.hscroll = bus_din;
                  s_next.state = ST_IDLE;
               end
               ST_PTR_SET: begin
                  if (!s_reg.idx) begin
                     s_next.cursor[7:0] = bus_din;
                     s_next.idx = 1'b1;
                  end else begin
                     s_next.cursor[15:8] = bus_din;
                     s_next.state = ST_IDLE;
                  end
               end
               ST_DEPTH: begin
                  s_next.depth = bus_din;
                  // Further bytes fall on idle and are dropped.
                  s_next.state = ST_IDLE;
               end
               ST_MWR: begin
                  mem_we = 1'b1;
                  s_next.cursor = s_reg.cursor + CURSOR_STEP;
               end
               default: s_next.state = s_reg.state;
            endcase
         end else if (par_re) begin
            case (s_reg.state)
               ST_PTR_RD: begin
                  s_next.dout = s_reg.idx ? s_reg.cursor[15:8]
                                          : s_reg.cursor[7:0];
                  s_next.dout_vld = 1'b1;
                  s_next.idx = 1'b1;
                  if (s_reg.idx) begin
                     s_next.state = ST_IDLE;
                  end
               end
               ST_MRD: begin
                  // Read data lag the cursor by one cycle, so reads
                  // must be spaced at least two cycles apart.
                  s_next.dout = mem_rdata;
                  s_next.dout_vld = 1'b1;
                  s_next.cursor = s_reg.cursor + CURSOR_STEP;
               end
               default: s_next.dout_vld = 1'b0;
            endcase
         end
      end else begin
         if (dir_wr) begin
            if (is_mem) begin
               mem_we = 1'b1;
               mem_waddr = dir_addr[MEM_AW-1:0];
            end else begin
               case (dir_addr)
                  OFS_GLYPH_BASE_LOW: s_next.glyph_base[7:0] = bus_din;
                  OFS_GLYPH_BASE_HIGH: s_next.glyph_base[15:8] = bus_din;
                  OFS_FINE_HSCROLL: s_next.hscroll = bus_din;
                  OFS_CURSOR_WR_LOW: s_next.cursor[7:0] = bus_din;
                  OFS_CURSOR_WR_HIGH: s_next.cursor[15:8] = bus_din;
                  OFS_PIXEL_DEPTH: s_next.depth = bus_din;
                  default: s_next.state = s_reg.state;
               endcase
            end
         end else if (dir_rd) begin
            s_next.dout_vld = !is_mem;
            s_next.rd_pend = is_mem;
            case (dir_addr)
               OFS_GLYPH_BASE_LOW: s_next.dout = s_reg.glyph_base[7:0];
               OFS_GLYPH_BASE_HIGH: s_next.dout = s_reg.glyph_base[15:8];
               OFS_FINE_HSCROLL: s_next.dout = s_reg.hscroll;
               OFS_CURSOR_WR_LOW, OFS_CURSOR_RB_LOW:
                  s_next.dout = s_reg.cursor[7:0];
               OFS_CURSOR_WR_HIGH, OFS_CURSOR_RB_HIGH:
                  s_next.dout = s_reg.cursor[15:8];
               OFS_PIXEL_DEPTH: s_next.dout = s_reg.depth;
               default: s_next.dout = UNMAPPED_READ;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign bus_dout = s_reg.dout;
   assign bus_dout_vld = s_reg.dout_vld;
   assign glyph_base = s_reg.glyph_base;
   assign glyph_addr = s_reg.glyph_addr;
   assign hscroll_px = s_reg.hscroll[HSCROLL_W-1:0];
   assign scrolled_byte = s_reg.scrolled;
   assign cursor_addr = s_reg.cursor;
   assign depth_sel = s_reg.depth[DEPTH_W-1:0];
   assign bpp_one = (depth_sel == DEPTH_1BPP);
   assign bpp_two = (depth_sel == DEPTH_2BPP);
   assign bpp_four = (depth_sel == DEPTH_4BPP);
   assign bpp_rsvd = (depth_sel == DEPTH_RSVD);

   logic ind_wr, ind_rd;
   assign ind_wr = ce && indirect_mode && !cmd_we && par_we;
   assign ind_rd = ce && indirect_mode && !cmd_we && !par_we && par_re;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_glyph_low_load: assert property (
      ind_wr && s_reg.state == ST_GLYPH && !s_reg.idx
      |=> glyph_base[7:0] == $past(bus_din) && s_reg.idx
         && glyph_base[15:8] == $past(glyph_base[15:8]))
      else $error("glyph base low byte not loaded first");
   a_glyph_high_load: assert property (
      ind_wr && s_reg.state == ST_GLYPH && s_reg.idx
      |=> glyph_base[15:8] == $past(bus_din) && s_reg.state == ST_IDLE
         && glyph_base[7:0] == $past(glyph_base[7:0]))
      else $error("glyph base high byte not loaded second");
   a_glyph_addr_calc: assert property (
      ce && $stable(glyph_base) |=> glyph_addr
         == $past({8'h00, char_code} * {11'h000, char_height} + glyph_base))
      else $error("glyph address not code times height plus base");
   a_cursor_stable: assert property (
      ce && !cmd_we && !par_we && !par_re && !dir_wr |=> $stable(cursor_addr))
      else $error("cursor changed without a loading event");
   a_cursor_autoinc: assert property (
      ind_wr && s_reg.state == ST_MWR
      |=> cursor_addr == $past(cursor_addr) + CURSOR_STEP)
      else $error("cursor did not advance once after memory write");
   a_mem_refused: assert property (
      indirect_mode && mem_we |-> s_reg.state == ST_MWR && par_we
         && mem_waddr == cursor_addr[MEM_AW-1:0])
      else $error("display memory written outside the cursor path");
   a_pointer_readback: assert property (
      ind_rd && s_reg.state == ST_PTR_RD && !s_reg.idx
      |=> bus_dout_vld && bus_dout == $past(cursor_addr[7:0]))
      else $error("first pointer read is not the cursor low byte");
   a_pointer_set: assert property (
      ind_wr && s_reg.state == ST_PTR_SET && s_reg.idx
      |=> cursor_addr[15:8] == $past(bus_din) && s_reg.state == ST_IDLE)
      else $error("set-pointer high byte not loaded");
   // Returning to idle is what makes any further byte fall away.
   a_depth_one_byte: assert property (
      ind_wr && s_reg.state == ST_DEPTH
      |=> depth_sel == $past(bus_din[1:0]) && s_reg.state == ST_IDLE)
      else $error("depth command took more than one parameter");
   a_depth_decode: assert property (
      $onehot({bpp_one, bpp_two, bpp_four, bpp_rsvd})
         && (bpp_one == (s_reg.depth[1:0] == DEPTH_1BPP)))
      else $error("depth decode is not one-hot");
   a_scroll_zero: assert property (
      ce && hscroll_px == 3'h0 |=> scrolled_byte == $past(comp_word[15:8]))
      else $error("zero scroll altered the composed byte");
   a_hscroll_load: assert property (
      ind_wr && s_reg.state == ST_HSCROLL
      |=> hscroll_px == $past(bus_din[HSCROLL_W-1:0]))
      else $error("fine scroll parameter not loaded");
   a_pointer_high: assert property (
      ind_rd && s_reg.state == ST_PTR_RD && s_reg.idx
      |=> bus_dout_vld && bus_dout == $past(cursor_addr[15:8]))
      else $error("second pointer read is not the cursor high byte");
   a_read_autoinc: assert property (
      ind_rd && s_reg.state == ST_MRD
      |=> cursor_addr == $past(cursor_addr) + CURSOR_STEP)
      else $error("cursor did not advance once after memory read");
   a_pointer_low: assert property (
      ind_wr && s_reg.state == ST_PTR_SET && !s_reg.idx
      |=> cursor_addr[7:0] == $past(bus_din)
         && cursor_addr[15:8] == $past(cursor_addr[15:8]))
      else $error("set-pointer low byte not loaded alone");
   a_reg_read_answer: assert property (
      ce && !indirect_mode && !dir_wr && dir_rd && !is_mem |=> bus_dout_vld)
      else $error("register read gave no answer in the next cycle");
   // The memory array is left out: only the control state is checked.
   a_ce_freeze: assert property (
      !ce |=> $stable(s_reg))
      else $error("state moved while the clock enable was low");

   c_mem_write_burst: cover property (
      ind_wr && s_reg.state == ST_MWR ##6 ind_wr && s_reg.state == ST_MWR);
   c_pointer_two_reads: cover property (
      ind_rd && s_reg.state == ST_PTR_RD ##6 ind_rd);
   c_direct_mem_read: cover property (
      ce && !indirect_mode && dir_rd && is_mem ##2 bus_dout_vld);
   c_depth_four: cover property (bpp_four);
endmodule // ldc_draw_ctrl

// file: testbench/ldc_host_model.sv
`timescale 1ns/1ps
// Host side of the command and direct ports.
module ldc_host_model import ldc_pkg::*; (
   input wire logic clk, // Core clock.
   output logic indirect_mode, // Port mode select.
   output logic cmd_we, // Command strobe.
   output logic par_we, // Parameter write strobe.
   output logic par_re, // Parameter read strobe.
   output logic [7:0] bus_din, // Write data.
   output logic dir_wr, // Direct write strobe.
   output logic dir_rd, // Direct read strobe.
   output logic [15:0] dir_addr, // Direct address.
   input wire logic [7:0] bus_dout, // Read data.
   input wire logic bus_dout_vld // Read data valid.
);
   initial begin
      indirect_mode = 1'b0;
      {cmd_we, par_we, par_re, dir_wr, dir_rd} = 5'h00;
      bus_din = 8'hA5;
      dir_addr = 16'h5AA5;
   end
   // Released strobes drop to zero and the write data flips to its inverse, so a design
   // that samples them late cannot pass on stale data by luck.
   task automatic xfer(input logic [4:0] k, input logic [15:0] a,
                       input logic [7:0] b, output logic [7:0] d);
      d = 'x;
      {cmd_we, par_we, par_re, dir_wr, dir_rd} = k;
      dir_addr = a;
      bus_din = b;
      @(posedge clk);
      #2;
      {cmd_we, par_we, par_re, dir_wr, dir_rd} = 5'h00;
      bus_din = ~b;
      // The address stays put until the slowest answer has come back.
      // A register answer already stands here, a memory answer one later.
      repeat (4) begin
         if (bus_dout_vld === 1'b1) begin
            d = bus_dout;
         end
         @(posedge clk);
         #2;
      end
      // An edge passes before the next call may drive the address again.
      dir_addr = ~a;
      @(posedge clk);
      #2;
   endtask
   task automatic set_mode(input logic m);
      indirect_mode = m;
      @(posedge clk);
      #2;
   endtask
endmodule // ldc_host_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top import ldc_pkg::*; ;
   logic clk, rst, ce, indirect_mode, cmd_we, par_we, par_re, dir_wr, dir_rd;
   logic [7:0] bus_din, char_code, bus_dout, scrolled_byte, rv;
   logic [15:0] dir_addr, comp_word, glyph_base, glyph_addr, cursor_addr, sh;
   logic [4:0] char_height;
   logic [2:0] hscroll_px;
   logic [1:0] depth_sel;
   logic bus_dout_vld, bpp_one, bpp_two, bpp_four, bpp_rsvd;
   int n_errors, check_count, cycles;
   logic [15:0] rst_ofs [5] = '{OFS_GLYPH_BASE_LOW, OFS_GLYPH_BASE_HIGH,
      OFS_CURSOR_RB_LOW, OFS_CURSOR_RB_HIGH, OFS_PIXEL_DEPTH};
   logic [7:0] wdat [3] = '{8'h11, 8'h22, 8'h33};

   ldc_draw_ctrl u_ldc_draw_ctrl (.clk(clk), .rst(rst), .ce(ce),
      .indirect_mode(indirect_mode), .cmd_we(cmd_we), .par_we(par_we),
      .par_re(par_re), .bus_din(bus_din), .dir_wr(dir_wr), .dir_rd(dir_rd),
      .dir_addr(dir_addr), .char_code(char_code), .char_height(char_height),
      .comp_word(comp_word), .bus_dout(bus_dout), .bus_dout_vld(bus_dout_vld),
      .glyph_base(glyph_base), .glyph_addr(glyph_addr),
      .hscroll_px(hscroll_px), .scrolled_byte(scrolled_byte),
      .cursor_addr(cursor_addr), .depth_sel(depth_sel), .bpp_one(bpp_one),
      .bpp_two(bpp_two), .bpp_four(bpp_four), .bpp_rsvd(bpp_rsvd));
   ldc_host_model u_ldc_host_model (.clk(clk), .indirect_mode(indirect_mode),
      .cmd_we(cmd_we), .par_we(par_we), .par_re(par_re), .bus_din(bus_din),
      .dir_wr(dir_wr), .dir_rd(dir_rd), .dir_addr(dir_addr),
      .bus_dout(bus_dout), .bus_dout_vld(bus_dout_vld));

   always #12.5 clk = ~clk;

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // The whole run needs a few hundred cycles; this leaves ample margin.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmd(input logic [7:0] b);
      u_ldc_host_model.xfer(5'h10, 16'h0000, b, rv);
   endtask
   task automatic par(input logic [7:0] b);
      u_ldc_host_model.xfer(5'h08, 16'h0000, b, rv);
   endtask
   task automatic rdi(input logic [7:0] e);
      u_ldc_host_model.xfer(5'h04, 16'h0000, 8'h00, rv);
      chk({8'h00, rv}, {8'h00, e});
   endtask
   task automatic dwr(input logic [15:0] a, input logic [7:0] b);
      u_ldc_host_model.xfer(5'h02, a, b, rv);
   endtask
   task automatic drd(input logic [15:0] a, input logic [7:0] e);
      u_ldc_host_model.xfer(5'h01, a, 8'h00, rv);
      chk({8'h00, rv}, {8'h00, e});
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      char_code = 8'h80;
      char_height = 5'h08;
      comp_word = 16'hA5C3;
      n_errors = 0;
      check_count = 0;
      cycles = 0;
      repeat (5) @(posedge clk);
      #2;
      rst = 1'b0;
      @(posedge clk);
      #2;
      chk({14'h0000, depth_sel}, 16'h0000);
      chk({15'h0000, bpp_one}, 16'h0001);
      for (int i = 0; i < 5; i++)
         drd(rst_ofs[i], 8'h00);
      $display("test reset_values done");
      dwr(OFS_GLYPH_BASE_LOW, 8'h34);
      dwr(OFS_GLYPH_BASE_HIGH, 8'h12);
      drd(OFS_GLYPH_BASE_LOW, 8'h34);
      drd(OFS_GLYPH_BASE_HIGH, 8'h12);
      chk(glyph_base, 16'h1234);
      dwr(OFS_CURSOR_RB_LOW, 8'hFF);
      drd(OFS_CURSOR_RB_LOW, 8'h00);
      drd(16'h8030, 8'h00);
      $display("test direct_registers done");
      u_ldc_host_model.set_mode(1'b1);
      cmd(CMD_GLYPH_BASE);
      par(8'h00);
      par(8'h60);
      chk(glyph_base, 16'h6000);
      chk(glyph_addr, 16'h6400);
      cmd(CMD_SET_POINTER);
      par(8'hFE);
      par(8'hFF);
      chk(cursor_addr, 16'hFFFE);
      // Bytes per row lives outside this block and is taken as set.
      cmd(CMD_FINE_HSCROLL);
      par(8'h03);
      sh = comp_word << 3;
      chk({13'h0000, hscroll_px}, 16'h0003);
      chk({8'h00, scrolled_byte}, {8'h00, sh[15:8]});
      chk(cursor_addr, 16'hFFFE);
      cmd(CMD_FINE_HSCROLL);
      par(8'h00);
      $display("test glyph_and_scroll done");
      for (int i = 0; i < 4; i++) begin
         cmd(CMD_DEPTH);
         par(8'(i));
         chk({14'h0000, depth_sel}, 16'(i));
         chk({12'h000, bpp_rsvd, bpp_four, bpp_two, bpp_one},
             16'h0001 << i);
      end
      // A single shared depth keeps every overlaid layer alike.
      cmd(CMD_DEPTH);
      par(8'(DEPTH_1BPP));
      par(8'h02);
      chk({14'h0000, depth_sel}, {14'h0000, DEPTH_1BPP});
      $display("test depth_codes done");
      cmd(CMD_MEM_WRITE);
      for (int i = 0; i < 3; i++)
         par(wdat[i]);
      chk(cursor_addr, 16'h0001);
      dwr(16'h7FFE, 8'h55);
      cmd(CMD_READ_POINTER);
      rdi(8'h01);
      rdi(8'h00);
      cmd(CMD_SET_POINTER);
      par(8'hFE);
      par(8'hFF);
      cmd(CMD_MEM_READ);
      for (int i = 0; i < 3; i++)
         rdi(wdat[i]);
      chk(cursor_addr, 16'h0001);
      $display("test cursor_memory done");
      u_ldc_host_model.set_mode(1'b0);
      drd(OFS_CURSOR_RB_LOW, 8'h01);
      drd(OFS_CURSOR_RB_HIGH, 8'h00);
      drd(16'h0000, 8'h33);
      drd(16'h7FFE, 8'h11);
      drd(OFS_GLYPH_BASE_HIGH, 8'h60);
      drd(OFS_PIXEL_DEPTH, 8'h00);
      $display("test direct_readback done");
      ce = 1'b0;
      dwr(OFS_GLYPH_BASE_LOW, 8'h77);
      chk(glyph_base, 16'h6000);
      ce = 1'b1;
      $display("test clock_enable done");
      tally_and_finish();
   end
endmodule // tb_top
